// File: logic/wpsh_pkg.sv
// constants, codes and carrier types of the power-save sequencer
// assumes a single 125 MHz clock shared by every user of the package
package wpsh_pkg;

	// clock and time base
	localparam int unsigned WPSH_CLK_PERIOD_PS = 8000;
	// one time unit is 1024 us
	localparam int unsigned WPSH_TU_PS         = 1024000000;
	localparam int unsigned WPSH_MS_PS         = 1000000000;
	localparam int unsigned WPSH_TU_CYCLES     = WPSH_TU_PS / WPSH_CLK_PERIOD_PS;
	localparam int unsigned WPSH_MS_CYCLES     = WPSH_MS_PS / WPSH_CLK_PERIOD_PS;
	localparam logic [15:0] WPSH_HOLD_DEFAULT_MS = 16'h0032;
	localparam int unsigned WPSH_PRE_W         = 17;

	// save level codes as the host writes them
	localparam logic [7:0] WPSH_CODE_OFF   = 8'h00;
	localparam logic [7:0] WPSH_CODE_RF    = 8'h01;
	localparam logic [7:0] WPSH_CODE_PIN   = 8'h02;
	localparam logic [7:0] WPSH_CODE_MSG   = 8'h03;
	localparam logic [7:0] WPSH_CODE_DEEP  = 8'h08;
	localparam logic [7:0] WPSH_CODE_DEEP9 = 8'h09;

	// retention select codes
	localparam logic [1:0] WPSH_RET_LP      = 2'h0;
	localparam logic [1:0] WPSH_RET_ULP_KEEP = 2'h1;
	localparam logic [1:0] WPSH_RET_ULP_LOSE = 2'h2;

	// beacon alignment and save procedure codes
	localparam logic       WPSH_ALIGN_BEACON = 1'b0;
	localparam logic       WPSH_ALIGN_DTIM   = 1'b1;
	localparam logic [1:0] WPSH_PSP_MAX      = 2'h0;
	localparam logic [1:0] WPSH_PSP_FAST     = 2'h1;
	localparam logic [1:0] WPSH_PSP_UAPSD    = 2'h2;

	// configuration options word
	localparam int unsigned WPSH_OPT_ALT_IND = 0;

	typedef enum logic [2:0] {
		WPSH_LV_OFF   = 3'h0,
		WPSH_LV_RF    = 3'h1,
		WPSH_LV_PIN   = 3'h2,
		WPSH_LV_MSG   = 3'h3,
		WPSH_LV_DEEP  = 3'h4,
		WPSH_LV_DEEP9 = 3'h5
	} wpsh_level_t;

	typedef enum logic [2:0] {
		WPSH_ST_ACTIVE   = 3'h0,
		WPSH_ST_SLEEP    = 3'h1,
		WPSH_ST_BEACON   = 3'h2,
		WPSH_ST_HOST     = 3'h3,
		WPSH_ST_ACK_WAIT = 3'h4,
		WPSH_ST_DEEP     = 3'h5,
		WPSH_ST_STAY     = 3'h6
	} wpsh_state_t;

	typedef enum logic [1:0] {
		WPSH_MSG_NONE      = 2'h0,
		WPSH_MSG_WAKE      = 2'h1,
		WPSH_MSG_SLEEP_REQ = 2'h2,
		WPSH_MSG_COLD_WAKE = 2'h3
	} wpsh_msg_t;

	// one power-mode command as the host issues it
	typedef struct packed {
		logic [7:0]  power_save_level;
		logic [1:0]  retention;
		logic        beacon_align;
		logic [1:0]  procedure;
		logic [15:0] hold_ms;
		logic [7:0]  beacon_skip_count;
		logic [15:0] max_sleep_tu;
		logic [7:0]  options;
	} wpsh_cmd_t;

	// configuration in force
	typedef struct packed {
		wpsh_level_t level;
		logic        ulp;
		logic        lose_state;
		logic        dtim_align;
		logic        fast;
		logic [15:0] hold_ms;
		logic [7:0]  skip;
		logic [15:0] max_tu;
		logic        alt_ind;
	} wpsh_cfg_t;

endpackage

// File: logic/wpsh_unit_timer.sv
// down counter in units of a fixed number of clock cycles
// assumes start_in and clk_en_in come from the same clock domain
`timescale 1ns/1ps
module wpsh_unit_timer
	import wpsh_pkg::*;
#(
	parameter int unsigned UNIT_CYCLES = WPSH_TU_CYCLES
) (
	input  wire logic        ref_clk_in,
	input  wire logic        reset_in,
	input  wire logic        clk_en_in,
	input  wire logic        start_in,
	input  wire logic [15:0] units_in,
	output logic             busy_out,
	output logic             expired_out
);
	localparam logic [WPSH_PRE_W-1:0] PRE_LAST =
		WPSH_PRE_W'(UNIT_CYCLES - 1);

	logic [WPSH_PRE_W-1:0] pre;
	logic [15:0]           left;

	// a zero unit count never expires: callers use zero as no limit
	always_ff @(posedge ref_clk_in or posedge reset_in) begin
		if (reset_in) begin
			pre         <= '0;
			left        <= '0;
			expired_out <= 1'b0;
		end else if (clk_en_in) begin
			expired_out <= 1'b0;
			if (start_in) begin
				pre  <= '0;
				left <= units_in;
			end else if (left != '0) begin
				if (pre == PRE_LAST) begin
					pre  <= '0;
					left <= left - 16'h0001;
					if (left == 16'h0001)
						expired_out <= 1'b1;
				end else begin
					pre <= pre + WPSH_PRE_W'(1);
				end
			end
		end
	end

	assign busy_out = (left != '0);

endmodule // wpsh_unit_timer

// File: logic/wpsh_sequencer.sv
// power-save sequencer: sleep/wake cycle, pin handshake, messages
// assumes beacon, activity and message strobes are on ref_clk_in;
// wake request pins are asynchronous and are synchronised here
// Function
// [RQ1] decode save level: 0 off, 1/2/3/8/9
// [RQ2] retention 1 keeps memory, 2 loses state
// [RQ3] align wake to beacon or DTIM beacon
// [RQ4] procedure select: maximum, fast, UAPSD
// [RQ5] fast mode holds awake after each packet
// [RQ6] hold time defaults to 50 ms
// [RQ7] skip count n wakes at (n+1)th DTIM
// [RQ8] sleep never exceeds max interval in TU; code caps SLEEP state only, not deep, and sets no cap when interval is 0
// [RQ9] host re-enables saving to change interval
// [RQ10] level 1 sleeps radio only, DTIM wakes
// [RQ11] level 1 remote exchange only while awake
// [RQ12] level 2 host wakes via request pin
// [RQ13] level 2 indicate awake before host data; host data is also taken in a beacon wake with no indication
// [RQ14] request low grants sleep, indication drops
// [RQ15] levels 2, 3 send to host freely
// [RQ16] option bit 0 selects alternate indication pin
// [RQ17] level 3 wake message, ignore pin wakes
// [RQ18] host acks sleep request, then stays silent
// [RQ19] level 3 sleeps only after host ack
// [RQ20] level 8 wake pin chosen by retention
// [RQ21] level 8 kept state: awake until recommand
// [RQ22] level 8 lost state: send cold wake
// [RQ23] reset: awake, saving off, indications low
`timescale 1ns/1ps
module wpsh_sequencer
	import wpsh_pkg::*;
#(
	parameter int unsigned TU_UNIT_CYCLES = WPSH_TU_CYCLES,
	parameter int unsigned MS_UNIT_CYCLES = WPSH_MS_CYCLES
) (
	input  wire logic      ref_clk_in,
	input  wire logic      reset_in,
	input  wire logic      clk_en_in,
	input  wire wpsh_cmd_t cmd_in,
	input  wire logic      cmd_apply_in,
	input  wire logic      beacon_tick_in,
	input  wire logic      dtim_tick_in,
	input  wire logic      wake_window_done_in,
	input  wire logic      data_activity_in,
	input  wire logic      host_msg_valid_in,
	input  wire logic      host_msg_is_ack_in,
	input  wire logic      lp_wake_request_pin_in,
	input  wire logic      deep_wake_request_pin_in,
	output logic           wake_indication_pin_out,
	output logic           alt_wake_indication_pin_out,
	output logic           radio_sleep_out,
	output logic           core_sleep_out,
	output logic           ulp_active_out,
	output logic           retention_active_out,
	output logic           remote_xfer_allow_out,
	output logic           host_data_accept_out,
	output logic           host_rx_path_open_out,
	output logic           msg_valid_out,
	output wpsh_msg_t      msg_code_out,
	output logic           cmd_accepted_out
);
	wpsh_cfg_t   cfg;
	wpsh_cfg_t   next_cfg;
	wpsh_cfg_t   out_cfg;
	wpsh_state_t state;
	wpsh_state_t next_state;
	wpsh_level_t cmd_level;
	logic        cmd_valid;
	logic [1:0]  pin_s1;
	logic [1:0]  pin_s2;
	logic        req_lp;
	logic        req_deep;
	logic        req_sel;
	logic [7:0]  skip_cnt;
	logic        done_seen;
	logic        wake_evt;
	logic        hold_busy;
	logic        max_expired;
	logic        sleep_start;
	logic        cold_wake;
	logic        next_ind;
	wpsh_msg_t   next_msg;

	// two-flop synchronisers for the asynchronous request pins
	genvar gi;
	generate
		for (gi = 0; gi < 2; gi++) begin : g_sync
			always_ff @(posedge ref_clk_in or posedge reset_in) begin
				if (reset_in) begin
					pin_s1[gi] <= 1'b0;
					pin_s2[gi] <= 1'b0;
				end else if (clk_en_in) begin
					pin_s1[gi] <= gi == 0 ? lp_wake_request_pin_in
						: deep_wake_request_pin_in;
					pin_s2[gi] <= pin_s1[gi];
				end
			end
		end
	endgenerate
	assign req_lp   = pin_s2[0];
	assign req_deep = pin_s2[1];
	// [RQ12] request pin by mode
	// [RQ20] pin follows retention
	assign req_sel  = cfg.ulp ? req_deep : req_lp;

	// [RQ1] level decode
	always_comb begin
		cmd_valid = 1'b1;
		case (cmd_in.power_save_level)
			WPSH_CODE_OFF:   cmd_level = WPSH_LV_OFF;
			WPSH_CODE_RF:    cmd_level = WPSH_LV_RF;
			WPSH_CODE_PIN:   cmd_level = WPSH_LV_PIN;
			WPSH_CODE_MSG:   cmd_level = WPSH_LV_MSG;
			WPSH_CODE_DEEP:  cmd_level = WPSH_LV_DEEP;
			WPSH_CODE_DEEP9: cmd_level = WPSH_LV_DEEP9;
			default: begin
				cmd_level = WPSH_LV_OFF;
				cmd_valid = 1'b0;
			end
		endcase
	end

	always_comb begin
		next_cfg            = cfg;
		next_cfg.level      = cmd_level;
		next_cfg.dtim_align = cmd_in.beacon_align == WPSH_ALIGN_DTIM;
		// [RQ4] procedure decode
		next_cfg.fast       = cmd_in.procedure == WPSH_PSP_FAST;
		// [RQ6] default hold time
		next_cfg.hold_ms    = cmd_in.hold_ms == '0 ?
			WPSH_HOLD_DEFAULT_MS : cmd_in.hold_ms;
		next_cfg.skip       = cmd_in.beacon_skip_count;
		next_cfg.alt_ind    = cmd_in.options[WPSH_OPT_ALT_IND];
		// [RQ2] retention only where the level allows it
		next_cfg.ulp        = 1'b0;
		next_cfg.lose_state = 1'b0;
		if (cmd_in.retention == WPSH_RET_ULP_KEEP)
			next_cfg.ulp = cmd_level inside {WPSH_LV_PIN, WPSH_LV_MSG,
				WPSH_LV_DEEP, WPSH_LV_DEEP9};
		if (cmd_in.retention == WPSH_RET_ULP_LOSE) begin
			next_cfg.ulp = cmd_level inside {WPSH_LV_DEEP,
				WPSH_LV_DEEP9};
			next_cfg.lose_state = next_cfg.ulp;
		end
		// [RQ9] interval taken only when saving was off
		if (cfg.level == WPSH_LV_OFF)
			next_cfg.max_tu = cmd_in.max_sleep_tu;
	end

	// [RQ23] start with saving off
	always_ff @(posedge ref_clk_in or posedge reset_in) begin
		if (reset_in) begin
			cfg <= '0;
		end else if (clk_en_in) begin
			if (cmd_apply_in && cmd_valid)
				cfg <= next_cfg;
			else if (cold_wake)
				cfg.level <= WPSH_LV_OFF;
		end
	end

	// outputs and the sleep cap see a command's settings in the edge that
	// takes it; the stored copy would lag one cycle and glitch the core
	assign out_cfg = (cmd_apply_in && cmd_valid) ? next_cfg : cfg;

	wpsh_unit_timer #(.UNIT_CYCLES(TU_UNIT_CYCLES)) u_max_sleep (
		.ref_clk_in  (ref_clk_in),
		.reset_in    (reset_in),
		.clk_en_in   (clk_en_in),
		.start_in    (sleep_start),
		.units_in    (out_cfg.max_tu),
		.busy_out    (),
		.expired_out (max_expired)
	);

	// [RQ5] hold restarts on every packet in fast mode
	wpsh_unit_timer #(.UNIT_CYCLES(MS_UNIT_CYCLES)) u_hold (
		.ref_clk_in  (ref_clk_in),
		.reset_in    (reset_in),
		.clk_en_in   (clk_en_in),
		.start_in    (data_activity_in && cfg.fast),
		.units_in    (cfg.hold_ms),
		.busy_out    (hold_busy),
		.expired_out ()
	);

	// [RQ7] count DTIM beacons slept through
	always_ff @(posedge ref_clk_in or posedge reset_in) begin
		if (reset_in)
			skip_cnt <= '0;
		else if (clk_en_in)
			if (state != WPSH_ST_SLEEP)
				skip_cnt <= '0;
			else if (dtim_tick_in && !wake_evt)
				skip_cnt <= skip_cnt + 8'h01;
	end

	always_ff @(posedge ref_clk_in or posedge reset_in) begin
		if (reset_in)
			done_seen <= 1'b0;
		else if (clk_en_in)
			done_seen <= state == WPSH_ST_BEACON &&
				(done_seen || wake_window_done_in);
	end

	// [RQ3] beacon or DTIM alignment
	// [RQ10] periodic DTIM wake
	// [RQ8] interval cap forces a wake
	assign wake_evt = max_expired ||
		(cfg.dtim_align ? dtim_tick_in && skip_cnt == cfg.skip
			: beacon_tick_in);
	assign sleep_start = next_state == WPSH_ST_SLEEP &&
		state != WPSH_ST_SLEEP;

	always_comb begin
		next_state = state;
		next_msg   = WPSH_MSG_NONE;
		cold_wake  = 1'b0;
		if (cmd_apply_in && cmd_valid) begin
			case (cmd_level)
				WPSH_LV_OFF:   next_state = WPSH_ST_ACTIVE;
				// [RQ21] recommand returns to deep sleep
				WPSH_LV_DEEP,
				WPSH_LV_DEEP9: next_state = WPSH_ST_DEEP;
				default:       next_state = WPSH_ST_SLEEP;
			endcase
		end else begin
			case (state)
				WPSH_ST_SLEEP: begin
					// [RQ17] level 3 ignores request pins
					if (cfg.level == WPSH_LV_PIN && req_sel)
						next_state = WPSH_ST_HOST;
					else if (wake_evt) begin
						next_state = WPSH_ST_BEACON;
						// [RQ17] wake message on every wake event
						if (cfg.level == WPSH_LV_MSG)
							next_msg = WPSH_MSG_WAKE;
					end
				end
				WPSH_ST_BEACON: begin
					if (cfg.level == WPSH_LV_PIN && req_sel)
						next_state = WPSH_ST_HOST;
					// [RQ5] no sleep while holding
					else if (done_seen && !hold_busy) begin
						if (cfg.level == WPSH_LV_MSG) begin
							next_state = WPSH_ST_ACK_WAIT;
							next_msg   = WPSH_MSG_SLEEP_REQ;
						end else
							next_state = WPSH_ST_SLEEP;
					end
				end
				// [RQ14] request low grants sleep
				WPSH_ST_HOST:
					if (!req_sel)
						next_state = WPSH_ST_SLEEP;
				// [RQ19] other messages keep us waiting
				WPSH_ST_ACK_WAIT:
					if (host_msg_valid_in && host_msg_is_ack_in)
						next_state = WPSH_ST_SLEEP;
				WPSH_ST_DEEP:
					if (req_sel) begin
						// [RQ22] state lost: cold wake, saving off
						if (cfg.lose_state) begin
							next_state = WPSH_ST_ACTIVE;
							next_msg   = WPSH_MSG_COLD_WAKE;
							cold_wake  = 1'b1;
						end else
							next_state = WPSH_ST_STAY;
					end
				WPSH_ST_ACTIVE,
				WPSH_ST_STAY: next_state = state;
				default:      next_state = WPSH_ST_ACTIVE;
			endcase
		end
	end

	always_ff @(posedge ref_clk_in or posedge reset_in) begin
		if (reset_in)
			state <= WPSH_ST_ACTIVE;
		else if (clk_en_in)
			state <= next_state;
	end

	// [RQ13] indication only once awake
	assign next_ind = next_state == WPSH_ST_HOST;

	// all outputs registered from the next state, except the message outputs, registered from the next message, and the accept flag, from the command strobe
	always_ff @(posedge ref_clk_in or posedge reset_in) begin
		if (reset_in) begin
			wake_indication_pin_out     <= 1'b0;
			alt_wake_indication_pin_out <= 1'b0;
			radio_sleep_out             <= 1'b0;
			core_sleep_out              <= 1'b0;
			ulp_active_out              <= 1'b0;
			retention_active_out        <= 1'b0;
			remote_xfer_allow_out       <= 1'b1;
			host_data_accept_out        <= 1'b1;
			host_rx_path_open_out       <= 1'b1;
			msg_valid_out               <= 1'b0;
			msg_code_out                <= WPSH_MSG_NONE;
			cmd_accepted_out            <= 1'b0;
		end else if (clk_en_in) begin
			// [RQ16] indication pin select
			wake_indication_pin_out     <= next_ind && !out_cfg.alt_ind;
			alt_wake_indication_pin_out <= next_ind && out_cfg.alt_ind;
			radio_sleep_out <= next_state inside {WPSH_ST_SLEEP,
				WPSH_ST_ACK_WAIT, WPSH_ST_DEEP};
			// [RQ10] level 1 keeps the core running
			core_sleep_out <= out_cfg.level != WPSH_LV_RF &&
				next_state inside {WPSH_ST_SLEEP, WPSH_ST_ACK_WAIT,
				WPSH_ST_DEEP};
			ulp_active_out <= out_cfg.ulp &&
				next_state inside {WPSH_ST_SLEEP, WPSH_ST_DEEP};
			retention_active_out <= out_cfg.ulp &&
				!out_cfg.lose_state &&
				next_state inside {WPSH_ST_SLEEP, WPSH_ST_DEEP};
			// [RQ11] remote exchange only while the radio is up
			remote_xfer_allow_out <= !(next_state inside
				{WPSH_ST_SLEEP, WPSH_ST_ACK_WAIT, WPSH_ST_DEEP});
			// [RQ11] level 1 takes host data at any time
			// [RQ13] level 2 host data waits for indication or a beacon wake
			host_data_accept_out <= out_cfg.level != WPSH_LV_PIN ||
				next_ind || next_state == WPSH_ST_BEACON;
			// [RQ15] receive path needs no handshake
			host_rx_path_open_out <= next_state != WPSH_ST_DEEP;
			msg_valid_out    <= next_msg != WPSH_MSG_NONE;
			msg_code_out     <= next_msg;
			cmd_accepted_out <= cmd_apply_in && cmd_valid;
		end
	end

	default clocking cb @(posedge ref_clk_in); endclocking
	default disable iff (reset_in);

	ps_off_awake_a: assert property ( // [RQ23]
		clk_en_in && !cmd_apply_in && state == WPSH_ST_ACTIVE
		|=> !radio_sleep_out && !core_sleep_out &&
		!wake_indication_pin_out && !alt_wake_indication_pin_out)
		else $error("awake state shows sleep or indication");

	rf_only_sleep_a: assert property ( // [RQ10]
		clk_en_in && !cmd_apply_in && state == WPSH_ST_SLEEP &&
		cfg.level == WPSH_LV_RF && !wake_evt
		|=> radio_sleep_out && !core_sleep_out)
		else $error("level 1 sleep not radio only");

	alt_pin_sel_a: assert property ( // [RQ16]
		(alt_wake_indication_pin_out |-> cfg.alt_ind) and
		(wake_indication_pin_out |-> !cfg.alt_ind))
		else $error("wrong indication pin driven");

	host_wake_ind_a: assert property ( // [RQ13]
		clk_en_in && !cmd_apply_in && state == WPSH_ST_HOST && req_sel
		|=> (wake_indication_pin_out || alt_wake_indication_pin_out)
		&& host_data_accept_out)
		else $error("no indication while host holds wake");

	grant_drop_a: assert property ( // [RQ14]
		clk_en_in && !cmd_apply_in && state == WPSH_ST_HOST && !req_sel
		|=> state == WPSH_ST_SLEEP && !wake_indication_pin_out &&
		!alt_wake_indication_pin_out)
		else $error("sleep grant not confirmed");

	l3_no_pin_a: assert property ( // [RQ17]
		clk_en_in && !cmd_apply_in && state == WPSH_ST_SLEEP &&
		cfg.level == WPSH_LV_MSG && !wake_evt
		|=> state == WPSH_ST_SLEEP)
		else $error("level 3 left sleep without beacon");

	ack_gate_a: assert property ( // [RQ19]
		clk_en_in && !cmd_apply_in && state == WPSH_ST_ACK_WAIT &&
		!(host_msg_valid_in && host_msg_is_ack_in)
		|=> state == WPSH_ST_ACK_WAIT && radio_sleep_out)
		else $error("slept without host ack");

	hold_block_a: assert property ( // [RQ5]
		clk_en_in && !cmd_apply_in && state == WPSH_ST_BEACON &&
		hold_busy |=> state != WPSH_ST_SLEEP)
		else $error("slept during activity hold");

	cold_msg_a: assert property ( // [RQ22]
		clk_en_in && !cmd_apply_in && state == WPSH_ST_DEEP &&
		cfg.lose_state && req_sel
		|=> msg_valid_out && msg_code_out == WPSH_MSG_COLD_WAKE
		##0 cfg.level == WPSH_LV_OFF)
		else $error("cold wake message missing");

	stay_awake_a: assert property ( // [RQ21]
		clk_en_in && !cmd_apply_in && state == WPSH_ST_STAY
		|=> state == WPSH_ST_STAY && !core_sleep_out)
		else $error("level 8 left awake state unbidden");

endmodule // wpsh_sequencer

// File: verification/wpsh_host_model.sv
// host-side partner: wake request pins and sleep-request acks
// assumes the bench steers pin choice, wake wish and ack delay
`timescale 1ns/1ps
module wpsh_host_model
	import wpsh_pkg::*;
(
	input  wire logic       clk_in,
	input  wire logic       reset_in,
	input  wire logic       use_deep_in,
	input  wire logic       want_wake_in,
	input  wire logic [7:0] ack_delay_in,
	input  wire logic       msg_valid_in,
	input  wire wpsh_msg_t  msg_code_in,
	output logic            lp_pin_out,
	output logic            deep_pin_out,
	output logic            ack_valid_out,
	output logic            ack_flag_out
);
	int   wait_cnt;
	logic quiet;

	always_comb begin
		lp_pin_out   = want_wake_in & ~use_deep_in;
		deep_pin_out = want_wake_in & use_deep_in;
	end

	// one ack, then silent until next wake
	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			wait_cnt      <= 0;
			quiet         <= 1'b0;
			ack_valid_out <= 1'b0;
			ack_flag_out  <= 1'b0;
		end else begin
			ack_valid_out <= 1'b0;
			// flag line is meaningless between messages: keep it moving
			ack_flag_out  <= ~ack_flag_out;
			if (msg_valid_in && msg_code_in == WPSH_MSG_WAKE)
				quiet <= 1'b0;
			if (msg_valid_in && msg_code_in == WPSH_MSG_SLEEP_REQ)
				wait_cnt <= int'(ack_delay_in) + 1;
			else if (wait_cnt > 0)
				wait_cnt <= wait_cnt - 1;
			if (wait_cnt == 1 && !quiet) begin
				ack_valid_out <= 1'b1;
				ack_flag_out  <= 1'b1;
				quiet         <= 1'b1;
			end
		end
	end
endmodule // wpsh_host_model

// File: verification/wpsh_sequencer_bench.sv
// self-checking bench of the power-save sequencer with a host model
// assumes short time units: 16 cycles a TU and 8 cycles a ms
`timescale 1ns/1ps
module wpsh_sequencer_bench;
	import wpsh_pkg::*;
	localparam int TU_T = 16;
	logic      clk = 1'b0, rst = 1'b1, apl = 1'b0;
	logic      btick = 1'b0, dtick = 1'b0, done = 1'b0, act = 1'b0;
	logic      use_deep = 1'b0, want = 1'b0;
	logic [7:0] ack_delay = 8'h04;
	wpsh_cmd_t cmd = '0;
	logic      lp, deep, hv, hack, ind, alt, rs, cs, ulp, ret;
	logic      rx, hda, rxo, mv, acc;
	wpsh_msg_t mc;
	int        bad_count = 0, cmp_count = 0, m_level = 0;
	logic      m_awake = 1'b1;
	logic [7:0] codes [10] = '{8'h04, 8'h01, 8'h07, 8'h02, 8'h0A,
		8'h03, 8'h08, 8'h09, 8'hFF, 8'h00};
	logic [1:0] psps [3] = '{2'h0, 2'h2, 2'h1};

	always #4 clk = ~clk;

	wpsh_sequencer #(.TU_UNIT_CYCLES(TU_T), .MS_UNIT_CYCLES(8))
	u_wpsh_sequencer (
		.ref_clk_in(clk), .reset_in(rst), .clk_en_in(1'b1),
		.cmd_in(cmd), .cmd_apply_in(apl), .beacon_tick_in(btick),
		.dtim_tick_in(dtick), .wake_window_done_in(done),
		.data_activity_in(act), .host_msg_valid_in(hv),
		.host_msg_is_ack_in(hack), .lp_wake_request_pin_in(lp),
		.deep_wake_request_pin_in(deep), .wake_indication_pin_out(ind),
		.alt_wake_indication_pin_out(alt), .radio_sleep_out(rs),
		.core_sleep_out(cs), .ulp_active_out(ulp),
		.retention_active_out(ret), .remote_xfer_allow_out(rx),
		.host_data_accept_out(hda), .host_rx_path_open_out(rxo),
		.msg_valid_out(mv), .msg_code_out(mc), .cmd_accepted_out(acc)
	);

	wpsh_host_model u_wpsh_host_model (
		.clk_in(clk), .reset_in(rst), .use_deep_in(use_deep),
		.want_wake_in(want), .ack_delay_in(ack_delay),
		.msg_valid_in(mv), .msg_code_in(mc), .lp_pin_out(lp),
		.deep_pin_out(deep), .ack_valid_out(hv), .ack_flag_out(hack)
	);

	task automatic report_and_stop();
		$display("comparisons %0d mismatches %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	task automatic chk(input logic got, input logic exp, input string s);
		cmp_count++;
		if (got !== exp) begin
			bad_count++;
			$display("mismatch at %0t: %s", $time, s);
		end
	endtask

	task automatic chk_msg(input wpsh_msg_t exp);
		cmp_count++;
		if (mv !== 1'b1 || mc !== exp) begin
			bad_count++;
			$display("mismatch at %0t: message %0d", $time, exp);
		end
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	task automatic pulse(ref logic s);
		s = 1'b1;
		tick(1);
		s = 1'b0;
	endtask

	function automatic logic pick(input int k);
		return k == 0 ? rs : (k == 1 ? (ind | alt) : mv);
	endfunction

	task automatic wait_for(input int k, input logic v, input int lim);
		int n;
		n = 0;
		while (pick(k) !== v && n < lim) begin
			tick(1);
			n++;
		end
		// a limit that runs out is a failure in its own right
		if (pick(k) !== v) begin
			bad_count++;
			$display("mismatch at %0t: wait %0d timed out", $time, k);
		end
	endtask

	// expected levels worked out from the model's level and wake state
	task automatic mchk();
		logic sl;
		sl = m_level != 0 && !m_awake;
		chk(rs, sl, "radio sleep");
		chk(cs, sl && m_level != 1, "core sleep");
		chk(rx, !sl, "remote exchange");
		if (m_level <= 2)
			chk(hda, !(sl && m_level == 2), "host data");
		chk(rxo, !(sl && m_level >= 8), "receive path");
	endtask

	task automatic apply(input logic [7:0] lvl, input logic [1:0] r);
		logic ok;
		ok = lvl inside {8'h00, 8'h01, 8'h02, 8'h03, 8'h08, 8'h09};
		cmd.power_save_level = lvl;
		cmd.retention = r;
		cmd.options[7:1] = 7'($urandom);
		pulse(apl);
		// the accept pulse stands only in the cycle after the command
		chk(acc, ok, "command accept");
		tick(1);
		if (ok) begin
			m_level = int'(lvl);
			m_awake = (lvl == 8'h00);
		end
		mchk();
	endtask

	task automatic sleep_again();
		pulse(done);
		wait_for(0, 1'b1, 10);
		m_awake = 1'b0;
		mchk();
	endtask

	initial begin
		#400000;
		bad_count++;
		$display("mismatch at %0t: watchdog ran out", $time);
		report_and_stop();
	end

	initial begin
		void'($urandom(32'hCD04));
		tick(3);
		rst = 1'b0;
		chk(ind | alt | mv | acc | ulp | ret, 1'b0, "reset");
		mchk();
		foreach (codes[i])
			apply(codes[i], 2'h0);
		$display("test codes done");
		// interval is only taken while saving is off
		cmd.max_sleep_tu = 16'h0002;
		apply(8'h01, 2'h0);
		wait_for(0, 1'b0, 2 * TU_T + 4);
		m_awake = 1'b1;
		mchk();
		sleep_again();
		apply(8'h00, 2'h0);
		cmd.max_sleep_tu = 16'h0000;
		apply(8'h01, 2'h0);
		tick(50);
		chk(rs, 1'b1, "no cap");
		$display("test interval done");
		cmd.beacon_align = 1'b1;
		cmd.beacon_skip_count = 8'($urandom % 3);
		apply(8'h01, 2'h0);
		pulse(btick);
		tick(1);
		chk(rs, 1'b1, "plain beacon");
		repeat (cmd.beacon_skip_count) begin
			pulse(dtick);
			tick(1);
			chk(rs, 1'b1, "skipped beacon");
		end
		pulse(dtick);
		tick(1);
		m_awake = 1'b1;
		mchk();
		sleep_again();
		cmd.beacon_align = 1'b0;
		apply(8'h01, 2'h0);
		pulse(btick);
		tick(1);
		m_awake = 1'b1;
		mchk();
		sleep_again();
		$display("test beacon done");
		cmd.hold_ms = 16'h0000;
		foreach (psps[i]) begin
			cmd.procedure = psps[i];
			apply(8'h01, 2'h0);
			pulse(btick);
			tick(1);
			pulse(act);
			pulse(done);
			tick(300);
			chk(rs, psps[i] != 2'h1, "hold");
			wait_for(0, 1'b1, 200);
			chk(rs, 1'b1, "hold end");
		end
		cmd.procedure = 2'h0;
		$display("test hold done");
		for (int i = 0; i < 2; i++) begin
			cmd.options[0] = i[0];
			use_deep = i[0];
			apply(8'h02, 2'(i));
			chk(ulp, i[0], "ulp level two");
			want = 1'b1;
			wait_for(1, 1'b1, 8);
			chk(ind, !i[0], "main indication");
			chk(alt, i[0], "alt indication");
			m_awake = 1'b1;
			mchk();
			tick(5);
			want = 1'b0;
			wait_for(0, 1'b1, 8);
			chk(ind | alt, 1'b0, "indication low");
			m_awake = 1'b0;
			mchk();
		end
		cmd.options[0] = 1'b0;
		$display("test pins done");
		cmd.beacon_align = 1'b1;
		cmd.beacon_skip_count = 8'h00;
		ack_delay = 8'(20 + $urandom % 8);
		apply(8'h03, 2'h1);
		want = 1'b1;
		tick(6);
		want = 1'b0;
		chk(ind | alt, 1'b0, "pin wake ignored");
		mchk();
		pulse(dtick);
		chk_msg(WPSH_MSG_WAKE);
		m_awake = 1'b1;
		pulse(done);
		wait_for(2, 1'b1, 10);
		chk_msg(WPSH_MSG_SLEEP_REQ);
		m_awake = 1'b0;
		mchk();
		pulse(dtick);
		tick(1);
		chk(mv, 1'b0, "wake before ack");
		tick(40);
		pulse(dtick);
		chk_msg(WPSH_MSG_WAKE);
		$display("test messages done");
		for (int r = 0; r < 3; r++) begin
			use_deep = (r != 0);
			apply(r == 1 ? 8'h09 : 8'h08, 2'(r));
			chk(ulp, r != 0, "ulp deep");
			chk(ret, r == 1, "retention");
			want = 1'b1;
			wait_for(r == 2 ? 2 : 0, r == 2, 8);
			if (r == 2) begin
				chk_msg(WPSH_MSG_COLD_WAKE);
				m_level = 0;
			end
			m_awake = 1'b1;
			want = 1'b0;
			tick(4);
			pulse(btick);
			tick(2);
			mchk();
		end
		apply(8'h01, 2'h0);
		$display("test deep done");
		report_and_stop();
	end
endmodule // wpsh_sequencer_bench
